// ==== design/ptec_pkg.sv ====
// Purpose: Constants and field layouts for the power and timer/interrupt control block.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses, one register per word.
// Notes:   Only the low byte of each register is used; upper bits read as zero.
package ptec_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  OFF_TIMER_CTRL  = 8'h88;
  localparam logic [7:0]  OFF_POWER_CTRL  = 8'h8c;
  localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h90;
  localparam logic [7:0]  OFF_IRQ_MASK    = 8'h94;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int          PC_BAUD_DOUBLE  = 7;
  localparam int          PC_VIEW_SEL     = 6;
  localparam int          PC_COLD_BOOT    = 4;
  localparam int          PC_SCRATCH1     = 3;
  localparam int          PC_SCRATCH0     = 2;
  localparam int          PC_DEEP_SLEEP   = 1;
  localparam int          PC_CPU_SLEEP    = 0;
  localparam logic [7:0]  PC_RESET        = 8'h00;
  localparam logic [7:0]  TC_RESET        = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  localparam int          EV_W            = 5;
  localparam int          EV_T0_OVF       = 0;
  localparam int          EV_T1_OVF       = 1;
  localparam int          EV_EXT0_EDGE    = 2;
  localparam int          EV_EXT1_EDGE    = 3;
  localparam int          EV_WAKE         = 4;
  localparam logic [4:0]  EV_RESET        = 5'h00;

  // Interrupt acknowledge lanes from the vectoring logic.
  localparam int          ACK_EXT0        = 0;
  localparam int          ACK_T0          = 1;
  localparam int          ACK_EXT1        = 2;
  localparam int          ACK_T1          = 3;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic baud_double;
    logic framing_flag_view_select;
    logic reserved5;
    logic cold_boot_flag;
    logic scratch_flag1;
    logic scratch_flag0;
    logic deep_sleep_request;
    logic cpu_only_sleep_request;
  } ptec_power_t;

  typedef struct packed {
    logic timer1_overflow_flag;
    logic timer1_run;
    logic timer0_overflow_flag;
    logic timer0_run;
    logic ext_irq1_flag;
    logic ext_irq1_type;
    logic ext_irq0_flag;
    logic ext_irq0_type;
  } ptec_timer_t;

endpackage

// ==== design/ptec_ctrl.sv ====
// Purpose: Power control and timer/external interrupt control registers with a Wishbone slave.
// Assumes: All inputs synchronous to clk_i except the interrupt pins, which are synchronised.
// Notes:   The block itself always runs on clk_i; the clock stop outputs gate other logic.
`timescale 1ns/100ps

// Functional notes
// - View select steers the serial top bit to the mode bit when 0, to the framing flag when 1.
// - The cold boot flag is set by power-on reset and keeps its value through any other reset.
// - The two scratch flags are plain read/write bits with no side effect.
// - Setting deep sleep stops the CPU clock and all peripheral clocks.
// - A wake-up clears the deep sleep bit so the waking interrupt is served and execution resumes.
// - Both sleep bits written together give deep sleep, and no CPU-only sleep after wake.
// - Setting CPU-only sleep stops the CPU clock while peripherals keep running.
// - A wake-up clears the CPU-only sleep bit so the waking interrupt is served.
// - The timer 1 overflow flag is set on overflow, cleared on its acknowledge, and writable.
// - The timer 1 run bit enables counting when 1 and holds the count when 0.
// - The timer 0 overflow flag is set on overflow, cleared on its acknowledge, and writable.
// - The timer 0 run bit enables counting when 1 and holds the count when 0.
// - In edge mode each external flag is set on a falling pin edge and held until cleared.
// - In level mode each external flag shows the inverted pin level and ignores writes.
// - Each type bit selects low-level triggering when 0 and falling-edge triggering when 1.
module ptec_ctrl (
  // Clock, reset and enable
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            por_i,
  input  wire logic                            ce_i,
  // Wishbone slave
  input  wire logic                            wb_cyc_i,
  input  wire logic                            wb_stb_i,
  input  wire logic                            wb_we_i,
  input  wire logic [ptec_pkg::ADDR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]                      wb_sel_i,
  input  wire logic [ptec_pkg::DATA_W-1:0]     wb_dat_i,
  output logic      [ptec_pkg::DATA_W-1:0]     wb_dat_o,
  output logic                                 wb_ack_o,
  // Sleep control and baud rate doubling
  input  wire logic                            wake_i,
  output logic                                 cpu_clk_stop_o,
  output logic                                 periph_clk_stop_o,
  output logic                                 baud_double_o,
  // Serial control top bit view
  input  wire logic                            uart_mode_bit_high_i,
  input  wire logic                            uart_framing_err_flag_i,
  input  wire logic                            uart_top_wr_i,
  input  wire logic                            uart_top_wdata_i,
  output logic                                 uart_top_rdata_o,
  output logic                                 uart_mode_wr_o,
  output logic                                 uart_framing_wr_o,
  output logic                                 uart_top_wdata_o,
  // Timers and external interrupts
  input  wire logic                            timer0_ovf_i,
  input  wire logic                            timer1_ovf_i,
  input  wire logic                            ext_irq0_pin_i,
  input  wire logic                            ext_irq1_pin_i,
  input  wire logic [3:0]                      irq_ack_i,
  output logic                                 timer0_run_o,
  output logic                                 timer1_run_o,
  output logic [3:0]                           irq_req_o,
  // Summary interrupt
  output logic                                 irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  ptec_pkg::ptec_power_t              power_ff;
  ptec_pkg::ptec_power_t              nxt_power;
  ptec_pkg::ptec_timer_t              timer_ff;
  ptec_pkg::ptec_timer_t              nxt_timer;
  logic [ptec_pkg::EV_W-1:0]          status_ff;
  logic [ptec_pkg::EV_W-1:0]          mask_ff;
  logic [ptec_pkg::EV_W-1:0]          events;
  logic [1:0]                         pin0_sync_ff;
  logic [1:0]                         pin1_sync_ff;
  logic                               pin0_prev_ff;
  logic                               pin1_prev_ff;
  logic                               fall0;
  logic                               fall1;
  logic                               bus_req;
  logic                               bus_wr;
  logic [7:0]                         wbyte;
  logic                               sleeping;

  function automatic logic hit(input logic [ptec_pkg::ADDR_W-1:0] adr,
                               input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  // One edge-mode flag: the hardware set wins over any clear in the same cycle.
  function automatic logic edge_flag(input logic cur, input logic set, input logic clr,
                                     input logic wr, input logic wval);
    if (set) begin
      edge_flag = 1'b1;
    end else if (clr) begin
      edge_flag = 1'b0;
    end else if (wr) begin
      edge_flag = wval;
    end else begin
      edge_flag = cur;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // A request is served in the cycle after it appears; ack then drops for one cycle.
  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
  assign wbyte    = wb_dat_i[7:0];
  assign sleeping = power_ff.deep_sleep_request | power_ff.cpu_only_sleep_request;

  assign fall0 = pin0_prev_ff & ~pin0_sync_ff[1];
  assign fall1 = pin1_prev_ff & ~pin1_sync_ff[1];

  assign events[ptec_pkg::EV_T0_OVF]    = timer0_ovf_i;
  assign events[ptec_pkg::EV_T1_OVF]    = timer1_ovf_i;
  assign events[ptec_pkg::EV_EXT0_EDGE] = fall0;
  assign events[ptec_pkg::EV_EXT1_EDGE] = fall1;
  assign events[ptec_pkg::EV_WAKE]      = wake_i & sleeping;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_dat_o <= '0;
      if (bus_req && !wb_we_i) begin
        if (hit(wb_adr_i, ptec_pkg::OFF_TIMER_CTRL)) begin
          wb_dat_o[7:0] <= timer_ff;
        end else if (hit(wb_adr_i, ptec_pkg::OFF_POWER_CTRL)) begin
          wb_dat_o[7:0] <= power_ff;
        end else if (hit(wb_adr_i, ptec_pkg::OFF_IRQ_STATUS)) begin
          wb_dat_o[ptec_pkg::EV_W-1:0] <= status_ff;
        end else if (hit(wb_adr_i, ptec_pkg::OFF_IRQ_MASK)) begin
          wb_dat_o[ptec_pkg::EV_W-1:0] <= mask_ff;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_power = power_ff;
    if (bus_wr && hit(wb_adr_i, ptec_pkg::OFF_POWER_CTRL)) begin
      nxt_power = wbyte;
      nxt_power.reserved5 = 1'b0;
    end
    if (wake_i && sleeping) begin
      nxt_power.deep_sleep_request     = 1'b0;
      nxt_power.cpu_only_sleep_request = 1'b0;
    end
  end

  // cold boot flag
  // Of the two resets only the power-on reset touches the cold boot flag; a plain reset leaves it alone.
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      power_ff                <= ptec_pkg::PC_RESET;
      power_ff.cold_boot_flag <= 1'b1;
    end else if (rst_i) begin
      power_ff                <= {ptec_pkg::PC_RESET[7:5], power_ff.cold_boot_flag,
                                  ptec_pkg::PC_RESET[3:0]};
    end else if (ce_i) begin
      power_ff <= nxt_power;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      cpu_clk_stop_o    <= 1'b0;
      periph_clk_stop_o <= 1'b0;
      baud_double_o     <= 1'b0;
    end else if (ce_i) begin
      cpu_clk_stop_o    <= nxt_power.deep_sleep_request | nxt_power.cpu_only_sleep_request;
      periph_clk_stop_o <= nxt_power.deep_sleep_request;
      baud_double_o     <= nxt_power.baud_double;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      uart_top_rdata_o  <= 1'b0;
      uart_mode_wr_o    <= 1'b0;
      uart_framing_wr_o <= 1'b0;
      uart_top_wdata_o  <= 1'b0;
    end else if (ce_i) begin
      uart_top_rdata_o  <= power_ff.framing_flag_view_select ? uart_framing_err_flag_i
                                                             : uart_mode_bit_high_i;
      uart_mode_wr_o    <= uart_top_wr_i & ~power_ff.framing_flag_view_select;
      uart_framing_wr_o <= uart_top_wr_i & power_ff.framing_flag_view_select;
      uart_top_wdata_o  <= uart_top_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  // The first stage feeds only the second; the edge compare looks at later stages.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin0_sync_ff <= 2'h3;
      pin1_sync_ff <= 2'h3;
      pin0_prev_ff <= 1'b1;
      pin1_prev_ff <= 1'b1;
    end else if (ce_i) begin
      pin0_sync_ff <= {pin0_sync_ff[0], ext_irq0_pin_i};
      pin1_sync_ff <= {pin1_sync_ff[0], ext_irq1_pin_i};
      pin0_prev_ff <= pin0_sync_ff[1];
      pin1_prev_ff <= pin1_sync_ff[1];
    end
  end

  logic tc_wr;
  assign tc_wr = bus_wr & hit(wb_adr_i, ptec_pkg::OFF_TIMER_CTRL);

  always_comb begin
    nxt_timer = timer_ff;
    if (tc_wr) begin
      nxt_timer.timer1_run    = wbyte[6];
      nxt_timer.timer0_run    = wbyte[4];
      nxt_timer.ext_irq1_type = wbyte[2];
      nxt_timer.ext_irq0_type = wbyte[0];
    end
    nxt_timer.timer1_overflow_flag = edge_flag(timer_ff.timer1_overflow_flag, timer1_ovf_i,
                                               irq_ack_i[ptec_pkg::ACK_T1], tc_wr, wbyte[7]);
    nxt_timer.timer0_overflow_flag = edge_flag(timer_ff.timer0_overflow_flag, timer0_ovf_i,
                                               irq_ack_i[ptec_pkg::ACK_T0], tc_wr, wbyte[5]);
    if (timer_ff.ext_irq1_type) begin
      nxt_timer.ext_irq1_flag = edge_flag(timer_ff.ext_irq1_flag, fall1,
                                          irq_ack_i[ptec_pkg::ACK_EXT1], tc_wr, wbyte[3]);
    end else begin
      nxt_timer.ext_irq1_flag = ~pin1_sync_ff[1];
    end
    if (timer_ff.ext_irq0_type) begin
      nxt_timer.ext_irq0_flag = edge_flag(timer_ff.ext_irq0_flag, fall0,
                                          irq_ack_i[ptec_pkg::ACK_EXT0], tc_wr, wbyte[1]);
    end else begin
      nxt_timer.ext_irq0_flag = ~pin0_sync_ff[1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_ff <= ptec_pkg::TC_RESET;
    end else if (ce_i) begin
      timer_ff <= nxt_timer;
    end
  end

  // Run bits leave as registered levels; the counters hold their bytes while low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer0_run_o <= 1'b0;
      timer1_run_o <= 1'b0;
      irq_req_o    <= 4'h0;
    end else if (ce_i) begin
      timer0_run_o <= nxt_timer.timer0_run;
      timer1_run_o <= nxt_timer.timer1_run;
      irq_req_o    <= {nxt_timer.timer1_overflow_flag, nxt_timer.ext_irq1_flag,
                       nxt_timer.timer0_overflow_flag, nxt_timer.ext_irq0_flag};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status: an event in the clearing cycle survives the write-one clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_ff <= ptec_pkg::EV_RESET;
    end else if (ce_i) begin
      if (bus_wr && hit(wb_adr_i, ptec_pkg::OFF_IRQ_STATUS)) begin
        status_ff <= (status_ff & ~wbyte[ptec_pkg::EV_W-1:0]) | events;
      end else begin
        status_ff <= status_ff | events;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= ptec_pkg::EV_RESET;
    end else if (ce_i && bus_wr && hit(wb_adr_i, ptec_pkg::OFF_IRQ_MASK)) begin
      mask_ff <= wbyte[ptec_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(status_ff & mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The edge after a reset still shows the reset value, so it is left out.
  view_select_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    ce_i && $past(ce_i) && !$past(rst_i) && !$past(por_i)
      |-> uart_top_rdata_o == ($past(power_ff.framing_flag_view_select)
      ? $past(uart_framing_err_flag_i) : $past(uart_mode_bit_high_i)))
    else $error("Serial top bit view does not follow the select.");

  cold_boot_set_a: assert property (@(posedge clk_i)
    por_i |=> power_ff.cold_boot_flag)
    else $error("Cold boot flag not set by power-on reset.");

  scratch_store_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    ce_i && bus_wr && hit(wb_adr_i, ptec_pkg::OFF_POWER_CTRL)
      |=> power_ff.scratch_flag1 == $past(wbyte[3]) && power_ff.scratch_flag0 == $past(wbyte[2]))
    else $error("Scratch flags did not store the written value.");

  deep_stop_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    power_ff.deep_sleep_request |-> periph_clk_stop_o && cpu_clk_stop_o)
    else $error("Deep sleep did not stop all clocks.");

  wake_clear_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    ce_i && wake_i && power_ff.deep_sleep_request |=> !power_ff.deep_sleep_request
      ##0 !periph_clk_stop_o)
    else $error("Wake-up did not end deep sleep.");

  no_idle_after_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    ce_i && wake_i && power_ff.deep_sleep_request |=> !cpu_clk_stop_o)
    else $error("CPU-only sleep remained after deep sleep wake-up.");

  idle_only_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    power_ff.cpu_only_sleep_request && !power_ff.deep_sleep_request
      |-> cpu_clk_stop_o && !periph_clk_stop_o)
    else $error("CPU-only sleep gates the wrong clocks.");

  idle_wake_a: assert property (@(posedge clk_i) disable iff (rst_i || por_i)
    ce_i && wake_i && power_ff.cpu_only_sleep_request |=> !power_ff.cpu_only_sleep_request)
    else $error("Wake-up did not clear CPU-only sleep.");

  t1_flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && timer1_ovf_i |=> timer_ff.timer1_overflow_flag ##0 irq_req_o[3])
    else $error("Timer 1 overflow flag not set.");

  t0_ack_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && irq_ack_i[ptec_pkg::ACK_T0] && !timer0_ovf_i |=> !timer_ff.timer0_overflow_flag)
    else $error("Timer 0 flag not cleared by acknowledge.");

  run_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    timer1_run_o == timer_ff.timer1_run && timer0_run_o == timer_ff.timer0_run)
    else $error("Run outputs disagree with the run bits.");

  edge_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && timer_ff.ext_irq0_type && fall0 |=> timer_ff.ext_irq0_flag)
    else $error("Falling edge did not set the edge flag.");

  level_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !timer_ff.ext_irq1_type |=> timer_ff.ext_irq1_flag == !$past(pin1_sync_ff[1]))
    else $error("Level flag does not show the inverted pin.");

  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && $past(ce_i) |-> irq_o == |($past(status_ff) & $past(mask_ff)))
    else $error("Interrupt output does not follow masked status.");

endmodule

// ==== dv/ptec_far_model.sv ====
// Purpose: Far side of the control block: two timer counters and the vectoring logic.
// Assumes: A running timer overflows once every PERIOD clocks.
// Notes:   Acks are given only while ack_en_i is high, so a flag can be held for a look.
`timescale 1ns/100ps
module ptec_far_model #(
  parameter int PERIOD = 16
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control from the block, plus the ack enable from the bench
  input  wire logic       run0_i,
  input  wire logic       run1_i,
  input  wire logic       ack_en_i,
  input  wire logic [3:0] irq_req_i,
  // Events back to the block
  output logic            ovf0_o,
  output logic            ovf1_o,
  output logic      [3:0] irq_ack_o
);
  localparam logic [7:0] LAST = 8'(PERIOD - 1);
  logic [7:0] cnt0_ff;
  logic [7:0] cnt1_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // halted count kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt0_ff <= 8'h00;
      cnt1_ff <= 8'h00;
    end else begin
      if (run0_i) begin
        cnt0_ff <= (cnt0_ff == LAST) ? 8'h00 : cnt0_ff + 8'h01;
      end
      if (run1_i) begin
        cnt1_ff <= (cnt1_ff == LAST) ? 8'h00 : cnt1_ff + 8'h01;
      end
    end
  end

  assign ovf0_o = run0_i && (cnt0_ff == LAST);
  assign ovf1_o = run1_i && (cnt1_ff == LAST);

  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle ack
  // One lane at a time; the idle cycle lets the flag clear before the next look.
  always_ff @(posedge clk_i) begin
    if (rst_i || irq_ack_o != 4'h0) begin
      irq_ack_o <= 4'h0;
    end else if (ack_en_i) begin
      irq_ack_o <= irq_req_i & (~irq_req_i + 4'h1);
    end
  end
endmodule

// ==== dv/power_timer_extint_control_test.sv ====
// Purpose: Self-checking bench for the power and timer/interrupt control block.
// Assumes: One Wishbone master in the bench; timers and vectoring come from the far model.
// Notes:   Tasks run in order and later ones rely on status bits set by earlier ones.
`timescale 1ns/100ps
module power_timer_extint_control_test;
  logic        clk_i, rst_i, por_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wake_i;
  logic [7:0]  wb_adr_i, rd;
  logic [3:0]  wb_sel_i, irq_ack_i, irq_req_o;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        cpu_clk_stop_o, periph_clk_stop_o, baud_double_o, uart_top_rdata_o;
  logic        uart_mode_bit_high_i, uart_framing_err_flag_i, uart_top_wr_i, uart_top_wdata_i;
  logic        uart_mode_wr_o, uart_framing_wr_o, uart_top_wdata_o, irq_o, ack_en;
  logic        timer0_ovf_i, timer1_ovf_i, ext_irq0_pin_i, ext_irq1_pin_i;
  logic        timer0_run_o, timer1_run_o;
  int          mismatches, checks;

  ptec_ctrl dut (.*);
  ptec_far_model #(.PERIOD(16)) far (.clk_i(clk_i), .rst_i(rst_i), .run0_i(timer0_run_o),
    .run1_i(timer1_run_o), .ack_en_i(ack_en), .irq_req_i(irq_req_o), .ovf0_o(timer0_ovf_i),
    .ovf1_o(timer1_ovf_i), .irq_ack_o(irq_ack_i));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Holds the request until ack is seen; the next call starts one idle cycle later.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk(wb_ack_o, 1'b1);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00);
    chk(rd, exp);
  endtask

  task automatic pin(input logic k, input logic v);
    @(posedge clk_i);
    if (k) ext_irq1_pin_i <= v;
    else ext_irq0_pin_i <= v;
  endtask

  task automatic reset_only();
    @(posedge clk_i);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    rdc(8'h88, 8'h00);
    rdc(8'h8c, 8'h10);
    rdc(8'h98, 8'h00);
    wb(1'b1, 8'h8c, 8'h8c);
    rdc(8'h8c, 8'h8c);
    chk({baud_double_o, cpu_clk_stop_o}, 2'b10);
    wb(1'b1, 8'h8c, 8'h10);
    reset_only();
    rdc(8'h8c, 8'h10);
    wb(1'b1, 8'h8c, 8'h00);
    reset_only();
    rdc(8'h8c, 8'h00);
  endtask

  task automatic view(input logic sel);
    wb(1'b1, 8'h8c, {1'b0, sel, 6'h00});
    tick(2);
    chk(uart_top_rdata_o, !sel);
    uart_top_wr_i    <= 1'b1;
    uart_top_wdata_i <= sel;
    tick(1);
    uart_top_wr_i <= 1'b0;
    // The steering pulse stands for one cycle only, so it is looked at mid-cycle.
    @(negedge clk_i);
    chk({uart_mode_wr_o, uart_framing_wr_o, uart_top_wdata_o}, {!sel, sel, sel});
  endtask

  task automatic sleep(input logic [7:0] v, input logic deep);
    wb(1'b1, 8'h8c, v);
    tick(2);
    chk({cpu_clk_stop_o, periph_clk_stop_o}, {1'b1, deep});
    wake_i <= 1'b1;
    tick(1);
    wake_i <= 1'b0;
    tick(2);
    chk({cpu_clk_stop_o, periph_clk_stop_o}, 2'b00);
    rdc(8'h8c, 8'h00);
  endtask

  task automatic t_timer();
    wb(1'b1, 8'h88, 8'h10);
    tick(20);
    chk({timer0_run_o, irq_req_o}, 5'h12);
    wb(1'b1, 8'h88, 8'h20);
    tick(40);
    rdc(8'h88, 8'h20);
    ack_en <= 1'b1;
    tick(4);
    chk(irq_req_o, 4'h0);
    ack_en <= 1'b0;
    wb(1'b1, 8'h88, 8'h40);
    tick(20);
    chk({timer1_run_o, irq_req_o}, 5'h18);
    wb(1'b1, 8'h88, 8'h80);
    wb(1'b1, 8'h88, 8'h00);
    tick(40);
    chk(irq_req_o, 4'h0);
    wb(1'b1, 8'h88, 8'ha0);
    rdc(8'h88, 8'ha0);
    wb(1'b1, 8'h88, 8'h00);
  endtask

  task automatic ext(input logic k);
    logic [7:0] f, t;
    f = k ? 8'h08 : 8'h02;
    t = k ? 8'h04 : 8'h01;
    pin(k, 1'b0);
    tick(6);
    rdc(8'h88, f);
    wb(1'b1, 8'h88, 8'h00);
    rdc(8'h88, f);
    pin(k, 1'b1);
    tick(6);
    rdc(8'h88, 8'h00);
    wb(1'b1, 8'h88, t);
    pin(k, 1'b0);
    tick(6);
    pin(k, 1'b1);
    tick(6);
    rdc(8'h88, t | f);
    wb(1'b1, 8'h88, t);
    rdc(8'h88, t);
    pin(k, 1'b0);
    tick(6);
    ack_en <= 1'b1;
    tick(4);
    rdc(8'h88, t);
    ack_en <= 1'b0;
    pin(k, 1'b1);
    wb(1'b1, 8'h88, 8'h00);
  endtask

  task automatic t_irq();
    rdc(8'h90, 8'h1f);
    chk(irq_o, 1'b0);
    wb(1'b1, 8'h94, 8'h04);
    tick(3);
    chk(irq_o, 1'b1);
    wb(1'b1, 8'h90, 8'h04);
    tick(3);
    chk(irq_o, 1'b0);
    rdc(8'h90, 8'h1b);
    // A low clock enable must freeze the pin synchroniser and the level flag.
    ce_i           <= 1'b0;
    ext_irq0_pin_i <= 1'b0;
    tick(6);
    chk(irq_req_o[0], 1'b0);
    ce_i <= 1'b1;
    tick(4);
    chk(irq_req_o[0], 1'b1);
    ext_irq0_pin_i <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // The whole sequence needs under two thousand cycles.
  initial begin
    tick(20000);
    mismatches++;
    $display("ERROR %0t: timeout", $time);
    finish_test();
  end

  initial begin
    {rst_i, por_i, ce_i, wb_sel_i} = 7'h7f;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wake_i, ack_en} = '0;
    {uart_mode_bit_high_i, uart_framing_err_flag_i, uart_top_wr_i, uart_top_wdata_i} = 4'h9;
    {ext_irq0_pin_i, ext_irq1_pin_i} = 2'b11;
    mismatches = 0;
    checks = 0;
    tick(10);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    t_power();
    view(1'b0);
    view(1'b1);
    sleep(8'h01, 1'b0);
    sleep(8'h02, 1'b1);
    sleep(8'h03, 1'b1);
    t_timer();
    ext(1'b0);
    ext(1'b1);
    t_irq();
    finish_test();
  end
endmodule
